// ### hw/converter_event_status_bank.sv
// Event flag and live status register bank for a four-core converter.
// Assumes core monitor inputs are synchronous to aclk and held as levels.
`timescale 1ns/1ps
`default_nettype none

module converter_event_status_bank
   import event_bank_pkg::*;
#(
   parameter int SC_TIMEOUT = SC_TIMEOUT_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   // Write address channel
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // Write data channel
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // Write response channel
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // Read address channel
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // Read data channel
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Converter core monitors
   input wire logic [3:0] core_current_limit,
   input wire logic core0_power_good,
   input wire logic core0_below_short_level,
   input wire logic core0_enable,
   input wire logic thermal_shutdown,
   input wire logic thermal_warning,
   // Unmasked pending event request
   output logic event_request
);

   // Clear, then set: a set in the same cycle wins
   function automatic logic [7:0] w1c_update(input logic [7:0] cur,
                                             input logic [7:0] set,
                                             input logic [7:0] clr);
      w1c_update = (cur & ~clr) | set;
   endfunction : w1c_update

   // Word address to register index
   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[ADDR_W-1:2];
   endfunction : reg_index

   localparam logic [16:0] TIMEOUT_LOAD = 17'(SC_TIMEOUT);
   localparam logic [16:0] TIMER_ONE = 17'h0_0001;

   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic aw_have_reg, w_have_reg;
   logic [7:0] aw_idx_reg;
   logic [7:0] wbyte_reg;
   logic wlane_reg;
   logic [7:0] ev01_reg, ev23_reg, mask01_reg, mask23_reg;
   logic [3:0] ilim_prev_reg;
   logic pg_prev_reg, below_prev_reg, en_prev_reg, started_reg;
   logic [16:0] timer_reg;
   logic event_request_reg;

   // Bus outputs straight from flops
   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;
   assign event_request = event_request_reg;

   // Handshakes and write decode
   wire aw_fire = awvalid & awready_reg;
   wire w_fire = wvalid & wready_reg;
   wire ar_fire = arvalid & arready_reg;
   wire wr_go = aw_have_reg & w_have_reg & ~bvalid_reg;
   wire wr_ok = wr_go & wlane_reg;
   wire hit_ev01 = aw_idx_reg == CORE01_EVENT_IDX;
   wire hit_ev23 = aw_idx_reg == CORE23_EVENT_IDX;
   wire hit_m01 = aw_idx_reg == CORE01_MASK_IDX;
   wire hit_m23 = aw_idx_reg == CORE23_MASK_IDX;
   wire [7:0] clr01 = (wr_ok & hit_ev01) ? wbyte_reg : 8'h00;
   wire [7:0] clr23 = (wr_ok & hit_ev23) ? wbyte_reg : 8'h00;

   wire [3:0] ilim_rise = core_current_limit & ~ilim_prev_reg;
   wire pg_rise = core0_power_good & ~pg_prev_reg;
   // Short-circuit detector, timer loaded on enable
   wire en_rise = core0_enable & ~en_prev_reg;
   // falling below the level after start-up
   wire sc_fall = core0_enable & started_reg & core0_below_short_level
                  & ~below_prev_reg;
   // start-up deadline passed while still below
   wire sc_timeout = core0_enable & ~en_rise & ~started_reg
                     & core0_below_short_level & (timer_reg == TIMER_ONE);
   wire sc_event = sc_fall | sc_timeout;

   // Set vectors for both event registers
   wire [7:0] set01 = {3'b000, ilim_rise[1], 1'b0, pg_rise, sc_event,
                       ilim_rise[0]};
   wire [7:0] set23 = {3'b000, ilim_rise[3], 3'b000, ilim_rise[2]};
   wire [7:0] ev01_next = w1c_update(ev01_reg, set01, clr01)
                          & CORE01_EVENT_BITS;
   wire [7:0] ev23_next = w1c_update(ev23_reg, set23, clr23)
                          & CORE23_EVENT_BITS;

   wire [3:0] pending = {ev23_reg[HI_ILIM_BIT], ev23_reg[LO_ILIM_BIT],
                         ev01_reg[HI_ILIM_BIT],
                         |ev01_reg[PG_BIT:LO_ILIM_BIT]};
   // Live status views and the pending summary view
   wire [7:0] thermal_view = {4'h0, thermal_shutdown, thermal_warning,
                              2'b00};
   wire [7:0] live01_view = {3'b000, core_current_limit[1], core0_enable,
                             ~core0_power_good, 1'b0,
                             core_current_limit[0]};
   wire [7:0] live23_view = {3'b000, core_current_limit[3], 3'b000,
                             core_current_limit[2]};
   wire [7:0] summary_view = {pending, 4'h0};

   // Read decode
   wire [7:0] ar_idx = reg_index(araddr);
   logic [7:0] rd_byte;
   logic rd_hit;
   always_comb begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      case (ar_idx)
         SUMMARY_IDX: rd_byte = summary_view;
         CORE01_EVENT_IDX: rd_byte = ev01_reg;
         CORE23_EVENT_IDX: rd_byte = ev23_reg;
         THERMAL_LIVE_IDX: rd_byte = thermal_view;
         CORE01_LIVE_IDX: rd_byte = live01_view;
         CORE23_LIVE_IDX: rd_byte = live23_view;
         CORE01_MASK_IDX: rd_byte = mask01_reg;
         CORE23_MASK_IDX: rd_byte = mask23_reg;
         default: rd_hit = 1'b0;
      endcase
   end

   wire wr_hit = hit_ev01 | hit_ev23 | hit_m01 | hit_m23
                 | (aw_idx_reg == SUMMARY_IDX)
                 | (aw_idx_reg == THERMAL_LIVE_IDX)
                 | (aw_idx_reg == CORE01_LIVE_IDX)
                 | (aw_idx_reg == CORE23_LIVE_IDX);

   // masked events kept off the request
   wire request_next = |((ev01_next & ~mask01_reg)
                         | (ev23_next & ~mask23_reg));

   // Write address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_idx_reg <= 8'h00;
         wbyte_reg <= 8'h00;
         wlane_reg <= 1'b0;
      end else begin
         if (aw_fire) begin
            aw_have_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_idx_reg <= reg_index(awaddr);
         end else if (wr_go) begin
            aw_have_reg <= 1'b0;
         end
         if (w_fire) begin
            w_have_reg <= 1'b1;
            wready_reg <= 1'b0;
            wbyte_reg <= wdata[7:0];
            wlane_reg <= wstrb[0];
         end else if (wr_go) begin
            w_have_reg <= 1'b0;
         end
         if (bvalid_reg && bready) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // Write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read channel, one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_fire) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h00_0000, rd_byte};
         rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   // Event flags, masks and request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev01_reg <= EVENT_RESET;
         ev23_reg <= EVENT_RESET;
         mask01_reg <= CORE01_MASK_RESET;
         mask23_reg <= CORE23_MASK_RESET;
         event_request_reg <= 1'b0;
      end else begin
         ev01_reg <= ev01_next;
         ev23_reg <= ev23_next;
         if (wr_ok && hit_m01)
            mask01_reg <= wbyte_reg & CORE01_MASK_BITS;
         if (wr_ok && hit_m23)
            mask23_reg <= wbyte_reg & CORE23_MASK_BITS;
         event_request_reg <= request_next;
      end
   end

   // Edge history of the monitors
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ilim_prev_reg <= 4'h0;
         pg_prev_reg <= 1'b0;
         below_prev_reg <= 1'b0;
         en_prev_reg <= 1'b0;
      end else begin
         ilim_prev_reg <= core_current_limit;
         pg_prev_reg <= core0_power_good;
         below_prev_reg <= core0_below_short_level;
         en_prev_reg <= core0_enable;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_reg <= 17'h0_0000;
         started_reg <= 1'b0;
      end else if (!core0_enable) begin
         timer_reg <= 17'h0_0000;
         started_reg <= 1'b0;
      end else if (en_rise) begin
         timer_reg <= TIMEOUT_LOAD;
         started_reg <= 1'b0;
      end else begin
         if (timer_reg != 17'h0_0000)
            timer_reg <= timer_reg - TIMER_ONE;
         if (!started_reg && (!core0_below_short_level
                              || timer_reg == TIMER_ONE))
            started_reg <= 1'b1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_ilim_latch: assert property (
      ilim_rise[2] |=> ev23_reg[LO_ILIM_BIT] && pending[2])
      else $error("current limit event not latched");

   chk_w1c_clear: assert property (
      wr_ok && hit_ev01 && wbyte_reg[PG_BIT] && !pg_rise
      |=> !ev01_reg[PG_BIT])
      else $error("write one did not clear flag");

   chk_flag_hold: assert property (
      ev01_reg[HI_ILIM_BIT] && !(wr_ok && hit_ev01)
      |=> ev01_reg[HI_ILIM_BIT])
      else $error("event flag lost without clear");

   chk_pg_latch: assert property (
      $rose(core0_power_good) |=> ev01_reg[PG_BIT])
      else $error("power good event missing");

   chk_sc_fall: assert property (
      core0_enable && started_reg && $rose(core0_below_short_level)
      |=> ev01_reg[SC_BIT])
      else $error("short fall event missing");

   chk_sc_timeout: assert property (
      en_rise ##1 (core0_enable && core0_below_short_level)[*8]
      |-> timer_reg == TIMEOUT_LOAD - 17'h0_0007)
      else $error("start-up timer not counting");

   chk_sc_expiry: assert property (
      sc_timeout |=> ev01_reg[SC_BIT] && started_reg)
      else $error("start-up timeout not latched");

   chk_live_thermal: assert property (
      ar_fire && ar_idx == THERMAL_LIVE_IDX
      |=> rdata_reg[TSD_BIT] == $past(thermal_shutdown)
          && rdata_reg[TWARN_BIT] == $past(thermal_warning))
      else $error("thermal live bits wrong");

   chk_live_core: assert property (
      ar_fire && ar_idx == CORE01_LIVE_IDX
      |=> rdata_reg[PG_BIT] == !$past(core0_power_good)
          && rdata_reg[ENABLED_BIT] == $past(core0_enable)
          && rdata_reg[HI_ILIM_BIT] == $past(core_current_limit[1]))
      else $error("core live bits wrong");

   // summary drops once core 0 flags are cleared
   chk_summary: assert property (
      wr_ok && hit_ev01 && set01[2:0] == 3'b000
      && (ev01_reg[2:0] & ~wbyte_reg[2:0]) == 3'b000 |=> !pending[0])
      else $error("summary set with empty register");

   chk_mask_gate: assert property (
      ev23_reg != 8'h00 && (ev23_reg & ~mask23_reg) == 8'h00
      && (ev01_reg & ~mask01_reg) == 8'h00
      && $stable(mask01_reg) && $stable(mask23_reg)
      |-> !event_request_reg)
      else $error("masked event raised request");

   chk_set_wins: assert property (
      ilim_rise[0] && wr_ok && hit_ev01 && wbyte_reg[LO_ILIM_BIT]
      |=> ev01_reg[LO_ILIM_BIT])
      else $error("clear overrode set");

   // Read answers within one cycle
   chk_read_resp: assert property (
      ar_fire |=> rvalid_reg && !arready_reg)
      else $error("read answer late");

endmodule : converter_event_status_bank

`default_nettype wire

// ### hw/event_bank_pkg.sv
// Constants for the converter event and live status register bank.
// Assumes a 32-bit AXI4-Lite register bus with one register per word.
package event_bank_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] SUMMARY_IDX = 8'h18;
   localparam logic [7:0] CORE01_EVENT_IDX = 8'h19;
   localparam logic [7:0] CORE23_EVENT_IDX = 8'h1a;
   localparam logic [7:0] THERMAL_LIVE_IDX = 8'h1b;
   localparam logic [7:0] CORE01_LIVE_IDX = 8'h1c;
   localparam logic [7:0] CORE23_LIVE_IDX = 8'h1d;
   localparam logic [7:0] CORE01_MASK_IDX = 8'h1f;
   localparam logic [7:0] CORE23_MASK_IDX = 8'h20;
   localparam int ADDR_W = 10;

   // Field positions in the paired-core registers
   localparam int LO_ILIM_BIT = 0;
   localparam int SC_BIT = 1;
   localparam int PG_BIT = 2;
   localparam int ENABLED_BIT = 3;
   localparam int HI_ILIM_BIT = 4;
   // Field positions in the thermal register
   localparam int TSD_BIT = 3;
   localparam int TWARN_BIT = 2;
   // Pending summary bits start here, one per core
   localparam int SUMMARY_LSB = 4;

   // Writable bit sets and reset values
   localparam logic [7:0] CORE01_EVENT_BITS = 8'h17;
   localparam logic [7:0] CORE23_EVENT_BITS = 8'h11;
   localparam logic [7:0] EVENT_RESET = 8'h00;
   localparam logic [7:0] CORE01_MASK_BITS = 8'h15;
   localparam logic [7:0] CORE23_MASK_BITS = 8'h11;
   localparam logic [7:0] CORE01_MASK_RESET = 8'h10;
   localparam logic [7:0] CORE23_MASK_RESET = 8'h11;

   // Bus response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Start-up deadline for the short-circuit detector
   localparam int CLK_MHZ = 125;
   localparam int SC_TIMEOUT_US = 1000;
   localparam int SC_TIMEOUT_CYCLES = SC_TIMEOUT_US * CLK_MHZ;

endpackage : event_bank_pkg

// ### tb/tb.sv
// Self-checking bench for the converter event and live status bank.
// Assumes the bank's package is compiled first; drives AXI4-Lite itself.
`timescale 1ns/1ps
`default_nettype none

module tb;
   import event_bank_pkg::*;

   localparam int SC_T = 20;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, event_request;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, core_current_limit;
   logic [1:0] bresp, rresp;
   logic core0_power_good, core0_below_short_level, core0_enable;
   logic thermal_shutdown, thermal_warning;
   logic [7:0] f01, f23, m01, m23;
   logic [1:0] r;
   int fail_count, checked, seed;
   logic [31:0] v;

   converter_event_status_bank #(.SC_TIMEOUT(SC_T)) DUT (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp),
      .core_current_limit(core_current_limit),
      .core0_power_good(core0_power_good),
      .core0_below_short_level(core0_below_short_level),
      .core0_enable(core0_enable), .thermal_shutdown(thermal_shutdown),
      .thermal_warning(thermal_warning), .event_request(event_request));

   // Free-running 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // Ends the run with the verdict
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      end_of_test();
   end

   task automatic chk(input string name, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", name, e, g);
         fail_count++;
      end
   endtask : chk

   function automatic logic mapped(input int i);
      return (i >= 'h18 && i <= 'h1d) || i == 'h1f || i == 'h20;
   endfunction : mapped

   // Unmasked pending flags drive the request
   function automatic logic exp_req();
      return |((f01 & ~m01 & 8'h17) | (f23 & ~m23 & 8'h11));
   endfunction : exp_req

   // Expected register contents from the model and driven monitors
   function automatic logic [7:0] exp_rd(input int i);
      case (i)
         'h18: return {f23[4], f23[0], f01[4], |f01[2:0], 4'h0};
         'h19: return f01;
         'h1a: return f23;
         'h1b: return {4'h0, thermal_shutdown, thermal_warning, 2'b00};
         'h1c: return {3'b000, core_current_limit[1], core0_enable,
                       ~core0_power_good, 1'b0, core_current_limit[0]};
         'h1d: return {3'b000, core_current_limit[3], 3'b000,
                       core_current_limit[2]};
         'h1f: return m01;
         'h20: return m23;
         default: return 8'h00;
      endcase
   endfunction : exp_rd

   // One AXI4-Lite write, both channels offered together
   task automatic axw(input int i, input logic [7:0] d,
                      input logic [3:0] s, output logic [1:0] resp);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= ADDR_W'(i * 4);
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : axw

   // One AXI4-Lite read, compared against the model
   task automatic rd(input int i);
      araddr <= ADDR_W'(i * 4);
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      chk($sformatf("rdata %h", i), {24'h00_0000, exp_rd(i)}, rdata);
      chk($sformatf("rresp %h", i), 32'(mapped(i) ? RESP_OKAY : RESP_SLVERR),
          32'(rresp));
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   // Write and track its effect in the model
   task automatic wr(input int i, input logic [7:0] d, input logic [3:0] s);
      axw(i, d, s, r);
      chk("bresp", 32'(mapped(i) ? RESP_OKAY : RESP_SLVERR), 32'(r));
      if (s[0] && mapped(i)) begin
         case (i)
            'h19: f01 = f01 & ~d;
            'h1a: f23 = f23 & ~d;
            'h1f: m01 = d & 8'h15;
            'h20: m23 = d & 8'h11;
            default: ;
         endcase
      end
   endtask : wr

   task automatic check_all;
      for (int i = 'h18; i <= 'h21; i++) rd(i);
      chk("event_request", 32'(exp_req()), 32'(event_request));
   endtask : check_all

   // New monitor levels; rising edges latch in the model
   task automatic drive_mon(input logic [3:0] il, input logic pg,
                            input logic en, input logic tsd, input logic tw);
      logic [3:0] up;
      up = il & ~core_current_limit;
      f01[0] = f01[0] | up[0];
      f01[4] = f01[4] | up[1];
      f23[0] = f23[0] | up[2];
      f23[4] = f23[4] | up[3];
      if (pg && !core0_power_good) f01[2] = 1'b1;
      core_current_limit <= il;
      core0_power_good <= pg;
      core0_enable <= en;
      thermal_shutdown <= tsd;
      thermal_warning <= tw;
      repeat (3) @(posedge aclk);
      chk("event_request", 32'(exp_req()), 32'(event_request));
   endtask : drive_mon

   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
      awaddr = '0;
      araddr = '0;
      awprot = 3'b000;
      arprot = 3'b000;
      wdata = 32'h0000_0000;
      wstrb = 4'h0;
      core_current_limit = 4'h0;
      {core0_power_good, core0_below_short_level, core0_enable} = 3'b000;
      {thermal_shutdown, thermal_warning} = 2'b00;
      f01 = 8'h00;
      f23 = 8'h00;
      m01 = CORE01_MASK_RESET;
      m23 = CORE23_MASK_RESET;
      fail_count = 0;
      checked = 0;
      seed = 6;
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      check_all();
      $display("test reset done");
      // Each core's current limit rises in turn
      for (int n = 0; n < 4; n++) begin
         drive_mon(4'(1 << n), 1'b0, 1'b0, 1'b0, 1'b0);
         check_all();
      end
      drive_mon(4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      $display("test current limit done");
      // Clearing only hits written ones; refused writes change nothing
      wr('h19, 8'h01, 4'h1);
      wr('h1a, 8'hff, 4'h0);
      wr('h1b, 8'hff, 4'h1);
      wr('h1e, 8'hff, 4'h1);
      check_all();
      wr('h1a, 8'h01, 4'h1);
      check_all();
      // Limit rises in the cycle the clear lands; the set must win
      fork
         wr('h19, 8'h01, 4'h1);
         begin
            @(posedge aclk);
            core_current_limit <= 4'h1;
         end
      join
      f01[0] = 1'b1;
      check_all();
      $display("test clear done");
      // Masks hold the request off but leave live bits alone
      wr('h1f, 8'hff, 4'h1);
      wr('h20, 8'hff, 4'h1);
      drive_mon(4'hf, 1'b1, 1'b0, 1'b0, 1'b0);
      check_all();
      wr('h1f, 8'h00, 4'h1);
      wr('h20, 8'h00, 4'h1);
      check_all();
      wr('h19, 8'hff, 4'h1);
      wr('h1a, 8'hff, 4'h1);
      drive_mon(4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      check_all();
      $display("test mask done");
      // Output never reaches the short level after enable
      core0_below_short_level <= 1'b1;
      drive_mon(4'h0, 1'b0, 1'b1, 1'b0, 1'b0);
      repeat (SC_T + 10) @(posedge aclk);
      f01[1] = 1'b1;
      check_all();
      wr('h19, 8'h02, 4'h1);
      core0_below_short_level <= 1'b0;
      repeat (3) @(posedge aclk);
      check_all();
      // Output drops below the short level while running
      core0_below_short_level <= 1'b1;
      repeat (3) @(posedge aclk);
      f01[1] = 1'b1;
      check_all();
      core0_below_short_level <= 1'b0;
      wr('h19, 8'h02, 4'h1);
      $display("test short circuit done");
      // Random monitor levels, live bits and latched events
      for (int k = 0; k < 8; k++) begin
         v = $random(seed);
         drive_mon(v[3:0], v[4], v[5], v[6], v[7]);
         check_all();
      end
      wr('h19, 8'hff, 4'h1);
      wr('h1a, 8'hff, 4'h1);
      check_all();
      $display("test random done");
      end_of_test();
   end

endmodule : tb

`default_nettype wire
